// >>> cidt_pkg.sv
// Package for the instruction decode and cycle timing block.
// Assumes a single 125 MHz core clock and active-low asynchronous reset.
`default_nettype none
package cidt_pkg;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int          INSN_W      = 24;
  localparam int          OPC_W       = 8;
  localparam int          OPC_LSB     = 16;
  localparam int          FILE_LSB    = 0;
  localparam int          FILE_W      = 13;
  localparam logic [12:0] FILE_MAX    = 13'h1fff;
  localparam int          DEST_BIT    = 14;
  localparam int          WB_LSB      = 15;
  localparam int          WS_LSB      = 0;
  localparam int          WD_LSB      = 7;
  localparam int          BITPOS_LSB  = 12;
  localparam int          TEN_BIT_LITERAL_LSB   = 4;
  localparam int          FIVE_BIT_LITERAL_LSB    = 0;
  localparam int          FOURTEEN_BIT_LITERAL_LSB   = 0;
  localparam int          BYTE_BIT    = 14;
  localparam int          COND_LSB    = 16;
  localparam int          VARZ_BIT    = 11;
  // ------------------------------------------------------------
  // Opcode values (coined encoding)
  // ------------------------------------------------------------
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_CALL2    = 8'h02;
  localparam logic [7:0] OP_GOTO2    = 8'h04;
  localparam logic [7:0] OP_DO2      = 8'h08;
  localparam logic [7:0] OP_CBRA_LO  = 8'h30;
  localparam logic [7:0] OP_CBRA_HI  = 8'h3e;
  localparam logic [7:0] OP_BRA      = 8'h37;
  localparam logic [7:0] OP_BRAW     = 8'h01;
  localparam logic [7:0] OP_CALLW    = 8'h03;
  localparam logic [7:0] OP_GOTOW    = 8'h05;
  localparam logic [7:0] OP_RET      = 8'h06;
  localparam logic [7:0] OP_RETI     = 8'h07;
  localparam logic [7:0] OP_TBL      = 8'hba;
  localparam logic [7:0] OP_MOVD     = 8'hbe;
  localparam logic [7:0] OP_SKIPC    = 8'haf;
  localparam logic [7:0] OP_SKIPS    = 8'hae;
  localparam logic [7:0] OP_TSTSET   = 8'ha4;
  localparam logic [7:0] OP_MOVOFS   = 8'h90;
  localparam logic [7:0] OP_ADDF     = 8'hb4;
  localparam logic [7:0] OP_ADDL10   = 8'hb0;
  localparam logic [7:0] OP_ADDL14   = 8'h20;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [22:0] PC_RESET = 23'h000000;
  localparam logic [4:0]  SR_RESET = 5'h00;
  localparam int          SR_C     = 0;
  localparam int          SR_DC    = 1;
  localparam int          SR_N     = 2;
  localparam int          SR_OV    = 3;
  localparam int          SR_Z     = 4;
  typedef enum logic [2:0] {
    CIDT_EXEC  = 3'b001,
    CIDT_FLUSH = 3'b010,
    CIDT_FL2   = 3'b100
  } cidt_state_type;
endpackage : cidt_pkg
`default_nettype wire

// >>> cidt_core.sv
// Instruction decode and cycle timing engine of a 16-bit core.
// Assumes program memory returns a 24-bit word each cycle for fetch_addr,
// and data memory answers a read combinationally in the same cycle.
//
// Functional notes
// - Single word is 24 bits; 8-bit opcode picks the type.
// - Only call, goto and loop-setup occupy two program words.
// - Second word of a double-word carries eight zero top bits.
// - A lone second word executes as a no-operation.
// - One cycle normally; two when test true or PC changes.
// - Branches, indirect transfers, table ops and returns take extra cycles.
// - Skip: one cycle, two over single word, three over double word.
// - Conditional branch: one cycle false, two taken, flag conditions.
// - Double moves and double-word instructions take two cycles.
// - Sixteen working registers; register zero is file accumulator.
// - File op result goes to file or register zero per dest bit.
// - Direct file address spans zero to 0x1fff.
// - Ten-bit literal limited by byte/word mode; 5 and 14 bit widths.
// - Offset move sign-extends ten-bit offset onto base register.
// - Long target literal has its lowest bit forced zero.
// - Bit position from four-bit field or base register contents.
// - Flags C DC N OV Z; zero sticky in carry-chained operations.
// - Skip-if-clear skips when selected bit is zero.
// - Test-then-set copies bit to C, or its complement to Z, then sets it.
`default_nettype none
module cidt_core (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Program memory fetch
  input  wire logic [23:0] insn_word,
  output logic      [22:0] fetch_addr,
  // Data memory
  input  wire logic [15:0] data_rdata,
  output logic      [15:0] data_addr,
  output logic      [15:0] data_wdata,
  output logic             data_we,
  // Observed state
  output logic      [4:0]  status_flags,
  output logic             insn_retired,
  output logic             flush_cycle
);
  import cidt_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cidt_state_type state_r;
  logic [22:0] pc_r;
  logic [15:0] accumulator_reg_zero_r [16];
  logic [4:0]  sr_r;
  logic [22:0] tgt_r;
  logic        second_r;   // next word is a second word
  logic [15:0] daddr_r, dwdata_r;
  logic        dwe_r, fl_r;
  logic        skip_fl_r;  // last executed word was a taken skip
  logic        jump_r;     // pending second word completes a call or jump

  // Field decode
  function automatic logic is_double(input logic [7:0] op);
    return (op == OP_CALL2) || (op == OP_GOTO2) || (op == OP_DO2);
  endfunction

  logic [7:0]  opc;
  logic [3:0]  wb_idx, ws_idx, wd_idx, bitpos;
  logic [12:0] faddr;
  logic [9:0]  ten_bit_literal;
  logic [4:0]  five_bit_literal;
  logic [13:0] fourteen_bit_literal;
  logic        exec;
  assign opc    = insn_word[OPC_LSB +: OPC_W];
  assign wb_idx = insn_word[WB_LSB -: 4];
  assign ws_idx = insn_word[WS_LSB +: 4];
  assign wd_idx = insn_word[WD_LSB +: 4];
  assign faddr  = insn_word[FILE_LSB +: FILE_W] & FILE_MAX;
  assign ten_bit_literal  = insn_word[BYTE_BIT] ? {2'b00, insn_word[TEN_BIT_LITERAL_LSB +: 8]}
                                      : insn_word[TEN_BIT_LITERAL_LSB +: 10];
  assign five_bit_literal   = insn_word[FIVE_BIT_LITERAL_LSB +: 5];
  assign fourteen_bit_literal  = insn_word[FOURTEEN_BIT_LITERAL_LSB +: 14];
  assign exec   = (state_r == CIDT_EXEC);

  // Bit selection and branch condition
  logic [15:0] bsrc, bsum, offs_addr;
  logic        bval, cond, skip, xfer, two;
  logic [16:0] sum17;
  always_comb begin
    bitpos = insn_word[VARZ_BIT] ? accumulator_reg_zero_r[wb_idx][3:0] : insn_word[BITPOS_LSB +: 4];
    bsrc   = insn_word[DEST_BIT] ? data_rdata : accumulator_reg_zero_r[ws_idx];
    bval   = bsrc[bitpos];
    case (insn_word[COND_LSB +: 4])
      4'h0:    cond = sr_r[SR_C];
      4'h1:    cond = ~(sr_r[SR_N] ^ sr_r[SR_OV]);
      4'h2:    cond = sr_r[SR_C];
      4'h3:    cond = ~sr_r[SR_Z] & ~(sr_r[SR_N] ^ sr_r[SR_OV]);
      4'h4:    cond = sr_r[SR_C] & ~sr_r[SR_Z];
      4'h5:    cond = sr_r[SR_Z] | (sr_r[SR_N] ^ sr_r[SR_OV]);
      4'h6:    cond = ~sr_r[SR_C] | sr_r[SR_Z];
      4'h7:    cond = 1'b1;
      4'h8:    cond = sr_r[SR_N] ^ sr_r[SR_OV];
      4'h9:    cond = ~sr_r[SR_C];
      4'ha:    cond = sr_r[SR_N];
      4'hb:    cond = ~sr_r[SR_N];
      4'hc:    cond = ~sr_r[SR_OV];
      4'hd:    cond = ~sr_r[SR_Z];
      4'he:    cond = sr_r[SR_OV];
      default: cond = sr_r[SR_Z];
    endcase
    // skip when bit clear, or set for the mirror form
    skip = exec && !second_r && (((opc == OP_SKIPC) && !bval) || ((opc == OP_SKIPS) && bval));
    // transfers that take extra cycles; conditional branches only when taken
    xfer = exec && !second_r && ((opc == OP_BRAW) || (opc == OP_CALLW) ||
           (opc == OP_GOTOW) || (opc == OP_RET) || (opc == OP_RETI) || (opc == OP_TBL) ||
           ((opc >= OP_CBRA_LO) && (opc <= OP_CBRA_HI) && cond));
    two  = exec && !second_r && ((opc == OP_MOVD) || is_double(opc));
    offs_addr = accumulator_reg_zero_r[wb_idx] + {{6{insn_word[TEN_BIT_LITERAL_LSB + 9]}}, insn_word[TEN_BIT_LITERAL_LSB +: 10]};
    bsum  = data_rdata + accumulator_reg_zero_r[0];
    sum17 = {1'b0, data_rdata} + {1'b0, accumulator_reg_zero_r[0]};
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // one extra cycle on taken transfer, two on return; two over a double word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= CIDT_EXEC;
    end else begin
      case (state_r)
        CIDT_EXEC:  state_r <= (skip || xfer || (two && !is_double(opc))) ? CIDT_FLUSH
                               : CIDT_EXEC;
        // Skipped word seen in the flush cycle decides on a third cycle
        CIDT_FLUSH: state_r <= (fl_r || (skip_fl_r && is_double(opc))) ? CIDT_FL2
                               : CIDT_EXEC;
        CIDT_FL2:   state_r <= CIDT_EXEC;
        default:    state_r <= CIDT_EXEC;
      endcase
    end
  end

  // Skip over a double word needs a second flush; returns also take three
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fl_r      <= 1'b0;
      skip_fl_r <= 1'b0;
    end else if (exec) begin
      // three cycles when skipped word is double
      skip_fl_r <= skip;
      fl_r      <= xfer && ((opc == OP_RET) || (opc == OP_RETI));
    end
  end

  // Second-word tracking
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      second_r <= 1'b0;
      jump_r   <= 1'b0;
      tgt_r    <= PC_RESET;
    end else if (exec) begin
      second_r <= is_double(opc) && !second_r;
      // Loop setup must not move the program counter
      jump_r   <= ((opc == OP_CALL2) || (opc == OP_GOTO2)) && !second_r;
      if (is_double(opc) && !second_r) begin
        tgt_r <= {7'h00, insn_word[15:1], 1'b0};
      end else if (second_r) begin
        tgt_r <= {insn_word[6:0], tgt_r[15:0]};
      end
    end
  end

  // Program counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_r <= PC_RESET;
    end else begin
      if (second_r && jump_r && exec && (opc[7:0] == 8'h00)) begin
        pc_r <= {insn_word[6:0], tgt_r[15:1], 1'b0};
      end else begin
        pc_r <= pc_r + 23'h000002;
      end
    end
  end

  // ------------------------------------------------------------
  // Datapath: registers, flags, memory
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) accumulator_reg_zero_r[i] <= 16'h0000;
      sr_r     <= SR_RESET;
      daddr_r  <= 16'h0000;
      dwdata_r <= 16'h0000;
      dwe_r    <= 1'b0;
    end else begin
      dwe_r <= 1'b0;
      // lone second word does nothing; flush cycles do nothing
      if (exec && !second_r) begin
        case (opc)
          OP_ADDF: begin
            // destination select; accumulator is register zero
            if (insn_word[DEST_BIT]) accumulator_reg_zero_r[0] <= bsum;
            else begin
              daddr_r  <= {3'b000, faddr};
              dwdata_r <= bsum;
              dwe_r    <= 1'b1;
            end
            sr_r[SR_C]  <= sum17[16];
            sr_r[SR_DC] <= (data_rdata[3:0] + accumulator_reg_zero_r[0][3:0]) > 5'h0f;
            sr_r[SR_N]  <= bsum[15];
            sr_r[SR_OV] <= (data_rdata[15] == accumulator_reg_zero_r[0][15]) && (bsum[15] != data_rdata[15]);
            sr_r[SR_Z]  <= (bsum == 16'h0000);
          end
          OP_ADDL10: begin
            accumulator_reg_zero_r[ws_idx] <= accumulator_reg_zero_r[ws_idx] + {6'h00, ten_bit_literal};
            // sticky zero: carry-chained form only clears
            if (accumulator_reg_zero_r[ws_idx] + {6'h00, ten_bit_literal} != 16'h0000) sr_r[SR_Z] <= 1'b0;
          end
          OP_ADDL14: accumulator_reg_zero_r[ws_idx] <= accumulator_reg_zero_r[wb_idx] + {2'b00, fourteen_bit_literal} + {11'h000, five_bit_literal};
          OP_MOVOFS: begin
            daddr_r  <= offs_addr;
            dwdata_r <= accumulator_reg_zero_r[ws_idx];
            dwe_r    <= 1'b1;
          end
          OP_TSTSET: begin
            if (insn_word[VARZ_BIT + 1]) sr_r[SR_Z] <= ~bval;
            else sr_r[SR_C] <= bval;
            if (insn_word[DEST_BIT]) begin
              daddr_r  <= {3'b000, faddr};
              dwdata_r <= data_rdata | (16'h0001 << bitpos);
              dwe_r    <= 1'b1;
            end else begin
              accumulator_reg_zero_r[ws_idx] <= accumulator_reg_zero_r[ws_idx] | (16'h0001 << bitpos);
            end
          end
          OP_MOVD: begin
            accumulator_reg_zero_r[wd_idx]         <= accumulator_reg_zero_r[ws_idx];
            accumulator_reg_zero_r[wd_idx + 4'h1]  <= accumulator_reg_zero_r[ws_idx + 4'h1];
          end
          default: ;
        endcase
      end
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      insn_retired <= 1'b0;
      flush_cycle  <= 1'b0;
    end else begin
      insn_retired <= exec;
      flush_cycle  <= !exec;
    end
  end
  assign fetch_addr   = pc_r;
  assign data_addr    = daddr_r;
  assign data_wdata   = dwdata_r;
  assign data_we      = dwe_r;
  assign status_flags = sr_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_flush_noop;
    @(posedge clock) disable iff (!nrst) !exec |=> !dwe_r;
  endproperty
  a_flush_noop: assert property (p_flush_noop) else $error("write in flush");
  property p_xfer_two;
    @(posedge clock) disable iff (!nrst) xfer && !fl_r |=> state_r == CIDT_FLUSH;
  endproperty
  a_xfer_two: assert property (p_xfer_two) else $error("transfer no flush");
  property p_skip_one;
    @(posedge clock) disable iff (!nrst) skip |=> !exec ##1 exec || state_r == CIDT_FL2;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip timing");
  property p_plain_one;
    @(posedge clock) disable iff (!nrst) exec && !skip && !xfer && !two |=> exec;
  endproperty
  a_plain_one: assert property (p_plain_one) else $error("plain not one cycle");
  property p_second_noop;
    @(posedge clock) disable iff (!nrst) second_r && exec |=> !dwe_r;
  endproperty
  a_second_noop: assert property (p_second_noop) else $error("second word acted");
  property p_pc_even;
    @(posedge clock) disable iff (!nrst) 1'b1 |-> fetch_addr[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("odd pc");
  c_skip: cover property (@(posedge clock) disable iff (!nrst) skip);
  c_xfer: cover property (@(posedge clock) disable iff (!nrst) xfer);
  c_fl2: cover property (@(posedge clock) disable iff (!nrst) state_r == CIDT_FL2);
endmodule // cidt_core
`default_nettype wire

// >>> cidt_mem_model.sv
// Program and data memory model facing the decode and timing core.
// Assumes one fetch per cycle and data reads answered in the same cycle.
`default_nettype none
module cidt_mem_model (
  // Clock
  input  wire logic        clock,
  // Program fetch
  input  wire logic [22:0] fetch_addr,
  output logic      [23:0] insn_word,
  // Data memory
  input  wire logic [15:0] data_addr,
  input  wire logic [15:0] data_wdata,
  input  wire logic        data_we,
  output logic      [15:0] data_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] prog [0:255];
  logic [15:0] dmem [0:8191];
  // ------------------------------------------------------------
  // Loading
  // ------------------------------------------------------------
  // Small store wraps, so any jump target lands on a filled word
  task automatic load(input logic [23:0] mark, input logic [23:0] w0,
                      input logic [23:0] w1, input logic [23:0] w2,
                      input logic [15:0] fill);
    logic [23:0] w [3];
    w = '{w0, w1, w2};
    for (int i = 0; i < 256; i++) begin
      prog[i] = (i < 3 && w[i] !== 24'hffffff) ? w[i] : mark; // Sentinel keeps marker
    end
    for (int i = 0; i < 8192; i++) begin
      dmem[i] = fill;
    end
  endtask
  // Fetch and read answer in the same cycle
  assign insn_word  = prog[fetch_addr[8:1]];
  assign data_rdata = dmem[data_addr[12:0]];
  // Writes land at the edge after the strobe
  always @(posedge clock) begin
    if (data_we === 1'b1) begin
      dmem[data_addr[12:0]] <= data_wdata;
    end
  end
endmodule // cidt_mem_model
`default_nettype wire

// >>> cidt_core_tb.sv
// Self-checking bench for the decode and cycle timing core.
// Assumes the memory model answers every fetch and read in the same cycle.
`default_nettype none
module cidt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int edges; logic [15:0] addr; int flushes;} cidt_note_type;
  typedef struct packed {
    logic [23:0] w0, w1, w2;
    logic [1:0]  fsel;
    logic [3:0]  cyc, fl;
  } cidt_row_type;
  localparam logic [23:0] M = 24'hffffff;
  // Words at 0, 2, 4; fill 0/ffff/random; cycles; flush count (f: unchecked)
  localparam cidt_row_type ROWS [18] = '{
    '{24'h000000, M, M, 2'd2, 4'd1, 4'd0},     // plain
    '{24'h001235, M, M, 2'd2, 4'd1, 4'd0},     // lone second word
    '{24'hb44000, M, M, 2'd2, 4'd1, 4'd0},     // result to register zero
    '{24'hb00000, M, M, 2'd2, 4'd1, 4'd0},     // ten-bit literal
    '{24'h200000, M, M, 2'd2, 4'd1, 4'd0},     // fourteen-bit literal
    '{24'h370001, M, M, 2'd2, 4'd2, 4'd1},     // relative branch
    '{24'h060000, M, M, 2'd1, 4'd3, 4'd2},     // return
    '{24'h070000, M, M, 2'd1, 4'd3, 4'd2},     // interrupt return
    '{24'hba0000, M, M, 2'd2, 4'd2, 4'hf},     // table access
    '{24'hbe0000, M, M, 2'd2, 4'd2, 4'hf},     // double move
    '{24'h040100, 24'h000123, M, 2'd2, 4'd2, 4'hf}, // jump, odd second word
    '{24'h020100, 24'h000124, M, 2'd2, 4'd2, 4'hf}, // call
    '{24'h080000, 24'h000010, M, 2'd2, 4'd2, 4'hf}, // loop setup
    '{24'haf0000, M, M, 2'd0, 4'd2, 4'd1},     // skip taken
    '{24'haf4000, M, M, 2'd1, 4'd1, 4'd0},     // no skip
    '{24'hae4000, M, M, 2'd1, 4'd2, 4'd1},     // skip if set taken
    '{24'hae4000, M, M, 2'd0, 4'd1, 4'd0},     // skip if set not taken
    '{24'haf0000, 24'h040100, 24'h000000, 2'd0, 4'd3, 4'd2} // over double
  };
  logic        clock;
  logic        nrst;
  logic [23:0] insn_word;
  logic [22:0] fetch_addr;
  logic [15:0] data_rdata;
  logic [15:0] data_addr;
  logic [15:0] data_wdata;
  logic        data_we;
  logic [4:0]  status_flags;
  logic        insn_retired;
  logic        flush_cycle;
  cidt_note_type notes [$];
  int          fail_count = 0;
  int          comparisons = 0;
  int          edges;
  int          flushes;
  logic        armed;

  cidt_core u_dut (.clock(clock), .nrst(nrst), .insn_word(insn_word),
    .fetch_addr(fetch_addr), .data_rdata(data_rdata), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .status_flags(status_flags),
    .insn_retired(insn_retired), .flush_cycle(flush_cycle));
  cidt_mem_model u_mem (.clock(clock), .fetch_addr(fetch_addr), .insn_word(insn_word),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
    .data_rdata(data_rdata));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Clock at 125 MHz
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Monitor: edges since reset, flushes, first data write against oldest note
  always @(posedge clock) begin : monitor
    cidt_note_type n;
    if (nrst !== 1'b1) begin
      edges = 0;
      flushes = 0;
      armed = 1'b1;
    end else begin
      edges++;
      #1;
      check(fetch_addr[0], 1'b0);
      if (flush_cycle === 1'b1 && armed) flushes++;
      if (data_we === 1'b1 && armed && notes.size() > 0) begin
        n = notes.pop_front();
        armed = 1'b0;
        check(edges, n.edges);
        check(data_addr, n.addr);
        check(insn_retired, 1'b1);
        if (n.flushes != 15) check(flushes, n.flushes);
      end
    end
  end

  // Driver: reset, load a short program, note the expected first write
  initial begin : driver
    cidt_note_type n;
    logic [12:0]   k;
    logic [15:0]   fill;
    logic [23:0]   w0;
    int            t;
    nrst = 1'b0;
    t = $urandom(32'h5cd9);
    repeat (8) @(posedge clock);
    #1;
    check(status_flags, 5'h00);
    check(fetch_addr, 23'h000000);
    for (int i = 0; i < 18; i++) begin
      @(posedge clock);
      nrst <= 1'b0;
      k = (i == 0) ? 13'h1fff : 13'($urandom_range(8191));
      fill = (ROWS[i].fsel == 2'd0) ? 16'h0000 :
             (ROWS[i].fsel == 2'd1) ? 16'hffff : 16'($urandom);
      w0 = ROWS[i].w0;
      if (w0[23:16] == 8'hb4) w0[12:0] = k ^ 13'h0001;
      u_mem.load({8'hb4, 3'h0, k}, w0, ROWS[i].w1, ROWS[i].w2, fill);
      n.edges = int'(ROWS[i].cyc) + 1;
      n.addr = {3'h0, k};
      n.flushes = int'(ROWS[i].fl);
      notes.push_back(n);
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      for (t = 0; t < 30 && notes.size() > 0; t++) @(posedge clock);
      if (notes.size() > 0) begin
        fail_count++;
        end_of_test();
      end
    end
    end_of_test();
  end
endmodule // cidt_core_tb
`default_nettype wire
